// File: rtl/adcsq_control.v
`timescale 1ns/100ps
`include "adcsq_consts.vh"
module adcsq_control #(
    parameter CLK_MHZ     = 250,
    parameter DATA_BITS   = 10
) (
    // apb
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [11:0]          paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output wire                 pready,
    output wire                 pslverr,
    // cpu power state
    input  wire                 cpu_halt,
    // converter cell
    output reg  [2:0]           mux_channel,
    output reg                  cell_enable,
    output reg                  cell_sample,
    output reg                  cell_step,
    input  wire                 cell_bit,
    // interrupt request
    output reg                  done_irq
);
    localparam STAB_CYCLES = (`ADCSQ_STAB_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam ST_IDLE   = 2'b00;
    localparam ST_SAMPLE = 2'b01;
    localparam ST_SAR    = 2'b10;
    // ****************************************
    // bus decode
    // ****************************************
    function hit;
        input [11:0] a;
        input [11:0] b;
        begin
            hit = (a == b);
        end
    endfunction
    wire acc    = psel & penable;
    wire wr     = acc & pwrite;
    wire rd     = acc & ~pwrite;
    wire wr_csr = wr & hit(paddr, `ADCSQ_ADDR_CSR);
    wire rd_hi  = rd & hit(paddr, `ADCSQ_ADDR_RES_HI);
    wire rd_lo  = rd & hit(paddr, `ADCSQ_ADDR_RES_LO);
    wire mapped = hit(paddr, `ADCSQ_ADDR_CSR) | hit(paddr, `ADCSQ_ADDR_RES_HI)
                | hit(paddr, `ADCSQ_ADDR_RES_LO) | hit(paddr, `ADCSQ_ADDR_MODE);
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    // ****************************************
    // state
    // ****************************************
    reg                 done_q;
    reg                 div4_q;
    reg                 on_q;
    reg                 irqen_q;
    reg                 single_q;
    reg  [2:0]          chan_q;
    reg  [DATA_BITS-1:0] result_q;
    reg  [DATA_BITS-1:0] sar_q;
    reg                 lock_q;
    reg  [1:0]          state_q;
    reg  [3:0]          step_q;
    reg  [1:0]          div_q;
    reg  [2:0]          halt_sync_q;
    reg  [15:0]         stab_q;
    wire halt_s = halt_sync_q[2] & halt_sync_q[1];
    wire [7:0] csr_rd = {done_q, div4_q, on_q, irqen_q, single_q, chan_q};
    // converter clock enable, cpu clock over two or four
    wire [1:0] div_last = div4_q ? `ADCSQ_DIV4_LAST : `ADCSQ_DIV2_LAST;
    wire tick = (div_q == div_last);
    wire running = (state_q != ST_IDLE);
    wire new_chan = wr_csr & (pwdata[`ADCSQ_CSR_CH_HI:`ADCSQ_CSR_CH_LO] != chan_q);
    wire wr_on = wr_csr & pwdata[`ADCSQ_CSR_ON];
    wire finish = running & tick & (state_q == ST_SAR) & (step_q == 4'h0);
    wire [DATA_BITS-1:0] sar_final = sar_q | {{(DATA_BITS-1){1'b0}}, cell_bit};
    // ****************************************
    // halt sync and stabilisation
    // ****************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halt_sync_q <= 3'h0;
            stab_q      <= 16'h0;
        end
        else
        begin
            halt_sync_q <= {halt_sync_q[1:0], cpu_halt};
            if (halt_s)
                stab_q <= STAB_CYCLES[15:0];
            else if (stab_q != 16'h0)
                stab_q <= stab_q - 16'h1;
        end
    end
    // ****************************************
    // control register and sequencer
    // ****************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_q   <= 1'b0;
            div4_q   <= 1'b0;
            on_q     <= 1'b0;
            irqen_q  <= 1'b0;
            single_q <= 1'b0;
            chan_q   <= 3'h0;
            result_q <= {DATA_BITS{1'b0}};
            sar_q    <= {DATA_BITS{1'b0}};
            lock_q   <= 1'b0;
            state_q  <= ST_IDLE;
            step_q   <= 4'h0;
            div_q    <= 2'h0;
            done_irq <= 1'b0;
        end
        else
        begin
            done_irq <= 1'b0;
            div_q <= tick ? 2'h0 : div_q + 2'h1;
            if (wr_csr)
            begin
                div4_q   <= pwdata[`ADCSQ_CSR_DIV4];
                on_q     <= pwdata[`ADCSQ_CSR_ON];
                irqen_q  <= pwdata[`ADCSQ_CSR_IRQEN];
                single_q <= pwdata[`ADCSQ_CSR_SINGLE];
                chan_q   <= pwdata[`ADCSQ_CSR_CH_HI:`ADCSQ_CSR_CH_LO];
            end
            if (rd_lo)
                lock_q <= 1'b1;
            if (rd_hi | (wr_csr & ~pwdata[`ADCSQ_CSR_ON]) | halt_s | (finish & single_q))
                lock_q <= 1'b0;
            if (finish)
                done_q <= 1'b1;
            else if (rd_hi)
                done_q <= 1'b0;
            else if (wr_on & ~running)
                done_q <= 1'b0;
            if (halt_s | (wr_csr & ~pwdata[`ADCSQ_CSR_ON]))
            begin
                state_q <= ST_IDLE;
                if (halt_s)
                    on_q <= 1'b0;
            end
            else if ((wr_on & ~running) | (running & new_chan))
            begin
                state_q <= ST_SAMPLE;
                step_q  <= `ADCSQ_SAMPLE_TICKS;
                sar_q   <= {DATA_BITS{1'b0}};
            end
            else if (running & tick)
            begin
                case (state_q)
                    ST_SAMPLE:
                    begin
                        step_q <= step_q - 4'h1;
                        if (step_q == 4'h1)
                        begin
                            state_q <= ST_SAR;
                            step_q  <= `ADCSQ_SAR_STEPS - 4'h1;
                        end
                    end
                    ST_SAR:
                    begin
                        sar_q <= {sar_q[DATA_BITS-2:0], cell_bit};
                        step_q <= step_q - 4'h1;
                        if (step_q == 4'h0)
                        begin
                            if (!lock_q)
                                result_q <= {sar_q[DATA_BITS-2:0], cell_bit};
                            done_irq <= irqen_q;
                            if (single_q)
                            begin
                                on_q    <= 1'b0;
                                state_q <= ST_IDLE;
                            end
                            else
                            begin
                                state_q <= ST_SAMPLE;
                                step_q  <= `ADCSQ_SAMPLE_TICKS;
                                sar_q   <= {DATA_BITS{1'b0}};
                            end
                        end
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end
    // ****************************************
    // converter cell drive
    // ****************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mux_channel <= 3'h0;
            cell_enable <= 1'b0;
            cell_sample <= 1'b0;
            cell_step   <= 1'b0;
        end
        else
        begin
            mux_channel <= chan_q;
            cell_enable <= on_q & ~halt_s;
            cell_sample <= (state_q == ST_SAMPLE);
            cell_step   <= (state_q == ST_SAR) & tick;
        end
    end
    // ****************************************
    // read data
    // ****************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel & ~penable & ~pwrite)
        begin
            prdata <= 32'h0;
            if (hit(paddr, `ADCSQ_ADDR_CSR))
                prdata[7:0] <= csr_rd;
            if (hit(paddr, `ADCSQ_ADDR_RES_HI))
                prdata[7:0] <= result_q[DATA_BITS-1:DATA_BITS-8];
            if (hit(paddr, `ADCSQ_ADDR_RES_LO))
                prdata[1:0] <= result_q[1:0];
            if (hit(paddr, `ADCSQ_ADDR_MODE))
            begin
                prdata[`ADCSQ_MODE_HALT]   <= halt_s;
                prdata[`ADCSQ_MODE_STABLE] <= (stab_q == 16'h0);
            end
        end
    end
    wire unused_ok = |sar_final;
endmodule

// File: shared/adcsq_consts.vh
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADCSQ_ADDR_CSR      12'h000
`define ADCSQ_ADDR_RES_HI   12'h004
`define ADCSQ_ADDR_RES_LO   12'h008
`define ADCSQ_ADDR_MODE     12'h00C
// ****************************************
// control/status field positions
// ****************************************
`define ADCSQ_CSR_DONE      7
`define ADCSQ_CSR_DIV4      6
`define ADCSQ_CSR_ON        5
`define ADCSQ_CSR_IRQEN     4
`define ADCSQ_CSR_SINGLE    3
`define ADCSQ_CSR_CH_HI     2
`define ADCSQ_CSR_CH_LO     0
`define ADCSQ_CSR_RESET     8'h00
// ****************************************
// mode register field positions
// ****************************************
`define ADCSQ_MODE_HALT     1
`define ADCSQ_MODE_STABLE   0
// ****************************************
// timing
// ****************************************
`define ADCSQ_SAMPLE_TICKS  4'h4
`define ADCSQ_SAR_STEPS     4'hA
`define ADCSQ_DIV2_LAST     2'h1
`define ADCSQ_DIV4_LAST     2'h3
`define ADCSQ_STAB_TIME_NS  1000
`endif

// File: verification/adcsq_control_props.sv
`timescale 1ns/100ps
`include "adcsq_consts.vh"
module adcsq_chk (
    // apb
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    // converter side
    input wire        cpu_halt,
    input wire [2:0]  mux_channel,
    input wire        cell_enable,
    input wire        cell_sample,
    input wire        done_irq
);
    reg  [7:0] csr_q;
    wire       acc    = psel && penable;
    wire       rd_csr = acc && !pwrite && paddr == `ADCSQ_ADDR_CSR;
    wire       wr_csr = acc && pwrite && paddr == `ADCSQ_ADDR_CSR;
    always @(posedge pclk or negedge presetn)
        if (!presetn) csr_q <= 8'h00;
        else if (wr_csr) csr_q <= pwdata[7:0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_irq_en; done_irq |-> csr_q[`ADCSQ_CSR_IRQEN]; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
    property p_irq_pulse; done_irq |=> !done_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
    property p_off; wr_csr && !pwdata[5] |-> ##[1:2] !cell_enable; endproperty
    a_off: assert property (p_off) else $error("converter not stopped");
    property p_chan; wr_csr |=> ##[0:1] mux_channel == csr_q[2:0]; endproperty
    a_chan: assert property (p_chan) else $error("wrong channel");
    property p_sample;
        $rose(cell_sample) |-> (cell_sample || psel || cpu_halt)[*6];
    endproperty
    a_sample: assert property (p_sample) else $error("sampling too short");
    property p_lo_rd;
        acc && !pwrite && paddr == `ADCSQ_ADDR_RES_LO |-> prdata[7:2] == 6'h00;
    endproperty
    a_lo_rd: assert property (p_lo_rd) else $error("low bits not zero");
    property p_csr_rd;
        rd_csr |-> prdata[6] == csr_q[6] && prdata[4:0] == csr_q[4:0];
    endproperty
    a_csr_rd: assert property (p_csr_rd) else $error("control bits lost");
    property p_halt; $rose(cpu_halt) |-> ##[1:6] !cell_enable; endproperty
    a_halt: assert property (p_halt) else $error("halt did not disable");
    property p_single; done_irq && csr_q[3] |-> ##[0:2] !cell_enable; endproperty
    a_single: assert property (p_single) else $error("on bit kept");
    property p_cont; done_irq && !csr_q[3] |-> ##[1:8] cell_sample; endproperty
    a_cont: assert property (p_cont) else $error("no restart");
endmodule
bind adcsq_control adcsq_chk i_adcsq_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .cpu_halt, .mux_channel, .cell_enable, .cell_sample, .done_irq);

// File: verification/adcsq_cell_model.sv
`timescale 1ns/100ps
module adcsq_cell_model (
    // converter cell
    input  wire        pclk,
    input  wire [2:0]  mux_channel,
    input  wire        cell_enable,
    input  wire        cell_sample,
    input  wire        cell_step,
    output wire        cell_bit,
    // levels already masked to their low ten bits per channel
    input  wire [79:0] levels
);
    reg  [3:0] idx_q = 4'h0;
    reg        tog_q = 1'b0;
    wire [9:0] lvl   = levels[mux_channel*10 +: 10];
    always @(posedge pclk)
        tog_q <= ~tog_q;
    always @(posedge pclk)
        if (cell_sample) idx_q <= 4'h0;
        else if (cell_step) idx_q <= idx_q + 4'h1;
    // msb first, unpowered cell toggles
    assign cell_bit = (cell_enable && idx_q < 4'hA) ? lvl[4'h9 - idx_q] : tog_q;
endmodule

// File: verification/adc_sequencer_control_test.sv
`timescale 1ns/100ps
`include "adcsq_consts.vh"
module adc_sequencer_control_test;
    reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    reg         pwrite = 1'b0, cpu_halt = 1'b0, err;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [79:0] levels = 80'h0;
    reg  [7:0]  rd;
    wire [31:0] prdata;
    wire [2:0]  mux_channel;
    wire        pready, pslverr, cell_enable, cell_sample, cell_step, cell_bit, done_irq;
    int         num_errors = 0, total_checks = 0, irqs = 0, seed = 77999;
    int         mv[8], ch, n, base, old;
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (done_irq === 1'b1) irqs <= irqs + 1;
    adcsq_control i_adcsq_control (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cpu_halt, .mux_channel, .cell_enable,
        .cell_sample, .cell_step, .cell_bit, .done_irq);
    adcsq_cell_model i_adcsq_cell_model (.pclk, .mux_channel, .cell_enable, .cell_sample,
        .cell_step, .cell_bit, .levels);
    // ****************************************
    // tasks
    // ****************************************
    task chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input w, input [11:0] a, input [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task setlv(input int c, input int v);
        mv[c] = v & 32'h3FF;
        levels[c*10 +: 10] <= v[9:0];
    endtask
    task wait_done;
        n = 0;
        do apb(0, `ADCSQ_ADDR_CSR, 8'h00); while (rd[7] !== 1'b1 && ++n < 100);
        chk(rd[7], 1'b1);
    endtask
    task wait_irqs(input int k);
        n = 0;
        while (irqs < base + k && ++n < 400) @(posedge pclk);
        chk(irqs >= base + k, 1'b1);
    endtask
    task chk_result(input int c);
        apb(0, `ADCSQ_ADDR_RES_LO, 8'h00);
        chk(rd, mv[c] & 32'h3);
        apb(0, `ADCSQ_ADDR_RES_HI, 8'h00);
        chk(rd, mv[c] >> 2);
        apb(0, `ADCSQ_ADDR_CSR, 8'h00);
        chk(rd[7], 1'b0);
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        #200000;
        num_errors++;
        finish_test;
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (ch = 0; ch < 8; ch++)
            setlv(ch, ch == 0 ? 32'h3FF : ch == 1 ? 32'h0 : $random(seed));
        apb(0, `ADCSQ_ADDR_RES_HI, 8'h00);
        chk(rd, 8'h00);
        apb(1, 12'h010, 8'hFF);
        chk(err, 1'b1);
        apb(1, `ADCSQ_ADDR_CSR, 8'h80);
        apb(0, `ADCSQ_ADDR_CSR, 8'h00);
        chk(rd, `ADCSQ_CSR_RESET);
        for (ch = 0; ch < 8; ch++)
        begin
            base = irqs;
            apb(1, `ADCSQ_ADDR_CSR, {ch[1], 1'b1, ch != 5, 1'b1, ch[2:0]});
            wait_done;
            chk(rd[5], 1'b0);
            chk(irqs - base, ch != 5);
            chk(mux_channel, ch);
            chk_result(ch);
        end
        apb(1, `ADCSQ_ADDR_CSR, 8'h2A);
        repeat (10) @(posedge pclk);
        apb(1, `ADCSQ_ADDR_CSR, 8'h2B);
        wait_done;
        chk_result(3);
        apb(1, `ADCSQ_ADDR_CSR, 8'h34);
        wait_done;
        apb(0, `ADCSQ_ADDR_RES_LO, 8'h00);
        chk(rd, mv[4] & 32'h3);
        old = mv[4];
        setlv(4, ~old);
        base = irqs;
        wait_irqs(2);
        apb(0, `ADCSQ_ADDR_RES_HI, 8'h00);
        chk(rd, old >> 2);
        base = irqs;
        wait_irqs(1);
        apb(0, `ADCSQ_ADDR_RES_LO, 8'h00);
        chk(rd, mv[4] & 32'h3);
        apb(0, `ADCSQ_ADDR_RES_HI, 8'h00);
        chk(rd, mv[4] >> 2);
        apb(1, `ADCSQ_ADDR_CSR, 8'h14);
        repeat (3) @(posedge pclk);
        chk(cell_enable, 1'b0);
        apb(1, `ADCSQ_ADDR_CSR, 8'h34);
        cpu_halt <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(0, `ADCSQ_ADDR_CSR, 8'h00);
        chk(rd[5], 1'b0);
        apb(0, `ADCSQ_ADDR_MODE, 8'h00);
        chk(rd, 8'h02);
        cpu_halt <= 1'b0;
        repeat (300) @(posedge pclk);
        apb(0, `ADCSQ_ADDR_MODE, 8'h00);
        chk(rd, 8'h01);
        finish_test;
    end
endmodule
